// >>> core/clm_macrocell_array.sv
// Programmable array of macrocells in four logic blocks, with APB access
// to configuration. Pins and dedicated inputs come from outside pclk and
// are synchronised; all cell logic is sampled on pclk.
`timescale 1ns/1ps
module clm_macrocell_array (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [13:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [clm_pkg::NDED-1:0]  ded_in,
   input  wire logic [clm_pkg::NPIN-1:0]  io_in,
   output logic      [clm_pkg::NPIN-1:0]  io_out,
   output logic      [clm_pkg::NPIN-1:0]  io_oe_n
);

   localparam int NC  = clm_pkg::NCELL;
   localparam int NP  = clm_pkg::NPT;
   localparam int PW  = clm_pkg::PT_IN_W;
   localparam int SMW = clm_pkg::SM_W;
   localparam int NB  = clm_pkg::NBLK;

   // One product term: AND of the true and complement selected inputs.
   // A term with no inputs selected is off, as unused terms are.
   function automatic logic pt_eval(input logic [PW-1:0] t,
                                    input logic [PW-1:0] c,
                                    input logic [PW-1:0] x);
      pt_eval = (|(t | c)) & (&(~t | x)) & (&(~c | ~x));
   endfunction : pt_eval

   // Pick one of the cell's terms; an index past the last gives low.
   function automatic logic pt_pick(input logic [NP-1:0] p,
                                    input logic [2:0]    i);
      pt_pick = (32'(i) < NP) ? p[i] : 1'b0;
   endfunction : pt_pick

   logic [NC-1:0]        ctl_en;
   logic [31:0]          ctl_q     [NC];
   logic [31:0]          ptsel_q   [NC];
   logic [PW-1:0]        pt_t_q    [NC][NP];
   logic [PW-1:0]        pt_c_q    [NC][NP];
   logic [7:0]           sm_sel_q  [NB][SMW];
   logic [15:0]          sig_q;
   logic                 fuse_q;
   logic [clm_pkg::NDED-1:0] ded_s1_q, ded_s2_q;
   logic [clm_pkg::NPIN-1:0] io_s1_q, io_s2_q;
   logic [NC-1:0]        cell_q, clk_prev_q, fb_q, fold_q;
   logic [clm_pkg::GB_W-1:0] gbus;
   logic [SMW-1:0]       sm_v      [NB];
   logic [NP-1:0]        pt_v      [NC];
   logic [NC-1:0]        sum_v, comb_v, d_v, clk_v, ce_v, clr_v, pre_v;
   logic [NC-1:0]        oe_v, fold_v, kr_v;
   logic                 acc, wr_go, is_cell, is_sm, cell_ok, sm_ok;
   logic [5:0]           a_cell;
   logic [4:0]           a_w;
   logic [2:0]           a_pt;
   logic [1:0]           a_blk;
   logic [3:0]           a_smw;
   logic [31:0]          rd_d;
   logic                 rd_err;

   // Two flops on every pin input before any cell logic looks at it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ded_s1_q <= '0;
         ded_s2_q <= '0;
         io_s1_q  <= '0;
         io_s2_q  <= '0;
      end else begin
         ded_s1_q <= ded_in;
         ded_s2_q <= ded_s1_q;
         io_s1_q  <= io_in;
         io_s2_q  <= io_s1_q;
      end
   end

   // Global bus carries dedicated pins, I/O pins and every buried feedback.
   assign gbus = {fb_q, io_s2_q, ded_s2_q};

   // Switch matrices; an out of range selector feeds a low level.
   always_comb begin
      for (int b = 0; b < NB; b++) begin
         for (int k = 0; k < SMW; k++) begin
            sm_v[b][k] = (32'(sm_sel_q[b][k]) < clm_pkg::GB_W) ?
                         gbus[sm_sel_q[b][k]] : 1'b0;
         end
      end
   end

   // Cell logic. Feedback and foldback enter the buses through flops, so
   // no configuration can close a combinational loop; cost is one cycle.
   always_comb begin
      for (int c = 0; c < NC; c++) begin
         logic [PW-1:0] bin;
         logic          prev, xin;
         bin = {fold_q[(c / clm_pkg::CPB) * clm_pkg::CPB +: clm_pkg::CPB],
                sm_v[c / clm_pkg::CPB]};
         prev = 1'b0;
         xin  = 1'b0;
         for (int p = 0; p < NP; p++) begin
            pt_v[c][p] = pt_eval(pt_t_q[c][p], pt_c_q[c][p], bin);
         end
         // Chains restart every eight cells, capping a sum at forty terms.
         prev = (c % clm_pkg::CAS_MAX == 0) ? 1'b0 :
                sum_v[(c == 0) ? 0 : c - 1];
         sum_v[c] = (|(pt_v[c] & ctl_q[c][clm_pkg::OR_MASK_LSB +: NP]))
                    | (ctl_q[c][clm_pkg::CAS_EN_BIT] & prev);
         kr_v[c] = pt_pick(pt_v[c],
                           ptsel_q[c][clm_pkg::XOR_PT_LSB +: 3]);
         case (ctl_q[c][clm_pkg::XOR_SEL_LSB +: 2])
            clm_pkg::XOR_LOW:  xin = 1'b0;
            clm_pkg::XOR_HIGH: xin = 1'b1;
            default:           xin = kr_v[c];
         endcase
         comb_v[c] = sum_v[c] ^ xin;
         case (ctl_q[c][clm_pkg::D_SEL_LSB +: 2])
            clm_pkg::DSEL_XOR: d_v[c] = comb_v[c];
            clm_pkg::DSEL_PT:  d_v[c] = pt_pick(pt_v[c],
                               ptsel_q[c][clm_pkg::DAT_PT_LSB +: 3]);
            default:           d_v[c] = io_s2_q[c % clm_pkg::NPIN];
         endcase
         case (ctl_q[c][clm_pkg::CLK_SEL_LSB +: 2])
            clm_pkg::CLK_PT: clk_v[c] = pt_pick(pt_v[c],
                             ptsel_q[c][clm_pkg::CLK_PT_LSB +: 3]);
            default:         clk_v[c] =
                             ded_s2_q[ctl_q[c][clm_pkg::CLK_SEL_LSB +: 2]];
         endcase
         // Enable only gates global clocks; a term clock ignores it.
         ce_v[c] = !ctl_q[c][clm_pkg::CE_EN_BIT]
                   || ctl_q[c][clm_pkg::CLK_SEL_LSB +: 2] == clm_pkg::CLK_PT
                   || pt_pick(pt_v[c],
                              ptsel_q[c][clm_pkg::CE_PT_LSB +: 3]);
         case (ctl_q[c][clm_pkg::CLR_SEL_LSB +: 2])
            clm_pkg::CLR_GLB: clr_v[c] = ded_s2_q[clm_pkg::GCLR_PIN];
            clm_pkg::CLR_PT:  clr_v[c] = pt_pick(pt_v[c],
                              ptsel_q[c][clm_pkg::CLR_PT_LSB +: 3]);
            clm_pkg::CLR_OR:  clr_v[c] = ded_s2_q[clm_pkg::GCLR_PIN] |
                              pt_pick(pt_v[c],
                              ptsel_q[c][clm_pkg::CLR_PT_LSB +: 3]);
            default:          clr_v[c] = 1'b0;
         endcase
         pre_v[c] = ctl_q[c][clm_pkg::PRE_EN_BIT] & pt_pick(pt_v[c],
                    ptsel_q[c][clm_pkg::PRE_PT_LSB +: 3]);
         case (ctl_q[c][clm_pkg::OE_SEL_LSB +: 3])
            clm_pkg::OE_ON:   oe_v[c] = 1'b1;
            clm_pkg::OE_DED0: oe_v[c] = ded_s2_q[clm_pkg::OE_PIN0];
            clm_pkg::OE_DED1: oe_v[c] = ded_s2_q[clm_pkg::OE_PIN1];
            clm_pkg::OE_IO:   oe_v[c] =
                              io_s2_q[ctl_q[c][clm_pkg::OE_PIN_LSB +: 6]];
            clm_pkg::OE_PT:   oe_v[c] = pt_pick(pt_v[c],
                              ptsel_q[c][clm_pkg::OE_PT_LSB +: 3]);
            default:          oe_v[c] = 1'b0;
         endcase
         fold_v[c] = ~pt_pick(pt_v[c],
                     ptsel_q[c][clm_pkg::FOLD_PT_LSB +: 3]);
      end
   end

   // Storage elements. Clear wins over preset and both win over the clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_q <= '0;
      end else begin
         for (int c = 0; c < NC; c++) begin
            if (clr_v[c]) begin
               cell_q[c] <= 1'b0;
            end else if (pre_v[c]) begin
               cell_q[c] <= 1'b1;
            end else if (ctl_q[c][clm_pkg::MODE_LSB +: 3] ==
                         clm_pkg::MODE_LAT) begin
               if (clk_v[c]) begin
                  cell_q[c] <= d_v[c];
               end
            end else if (clk_v[c] && !clk_prev_q[c] && ce_v[c]) begin
               case (ctl_q[c][clm_pkg::MODE_LSB +: 3])
                  clm_pkg::MODE_T:  cell_q[c] <= cell_q[c] ^ comb_v[c];
                  clm_pkg::MODE_JK: cell_q[c] <= (sum_v[c] & ~cell_q[c]) |
                                                 (~kr_v[c] & cell_q[c]);
                  clm_pkg::MODE_SR: cell_q[c] <= sum_v[c] |
                                                 (~kr_v[c] & cell_q[c]);
                  default:          cell_q[c] <= d_v[c];
               endcase
            end
         end
      end
   end

   // Previous selected clock level, for rising edge detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_q <= '0;
      end else begin
         clk_prev_q <= clk_v;
      end
   end

   // Feedback, foldback and pin drivers, all taken from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_q    <= '0;
         fold_q  <= '0;
         io_out  <= '0;
         io_oe_n <= '1;
      end else begin
         for (int c = 0; c < NC; c++) begin
            fb_q[c] <= ctl_q[c][clm_pkg::FB_REG_BIT] ?
                       cell_q[c] : comb_v[c];
         end
         fold_q <= fold_v;
         for (int c = 0; c < clm_pkg::NPIN; c++) begin
            io_out[c]  <= ctl_q[c][clm_pkg::OUT_REG_BIT] ?
                          cell_q[c] : comb_v[c];
            io_oe_n[c] <= ~oe_v[c];
         end
      end
   end

   // Address decode shared by reads and writes.
   assign acc     = psel && penable && !pready;
   assign wr_go   = psel && penable && pready && pwrite;  // Lands with pready.
   assign is_cell = !paddr[13];
   assign a_cell  = paddr[12:7];
   assign a_w     = paddr[6:2];
   assign a_pt    = a_w[4:2] - clm_pkg::W_PT_GRP;
   assign cell_ok = is_cell && (a_w == clm_pkg::W_CTL ||
                    a_w == clm_pkg::W_PTSEL ||
                    (a_w[4:2] >= clm_pkg::W_PT_GRP && 32'(a_pt) < NP));
   assign is_sm   = paddr[13:12] == clm_pkg::SM_BASE[13:12];
   assign a_blk   = paddr[7:6];
   assign a_smw   = paddr[5:2];
   assign sm_ok   = is_sm && paddr[11:8] == 4'h0 &&
                    32'(a_smw) < clm_pkg::SM_WRDS;

   // Configuration writes are dropped while the fuse is programmed.
   always_comb begin
      for (int c = 0; c < NC; c++) begin
         ctl_en[c] = wr_go && is_cell && !fuse_q && 32'(a_cell) == c;
      end
   end

   // Cell control and term selector words.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NC; c++) begin
            ctl_q[c]   <= clm_pkg::CFG_RST;
            ptsel_q[c] <= clm_pkg::CFG_RST;
         end
      end else begin
         for (int c = 0; c < NC; c++) begin
            if (ctl_en[c] && a_w == clm_pkg::W_CTL) begin
               ctl_q[c] <= pwdata;
            end
            if (ctl_en[c] && a_w == clm_pkg::W_PTSEL) begin
               ptsel_q[c] <= pwdata;
            end
         end
      end
   end

   // Product term input masks: true low, true high, complement low, high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NC; c++) begin
            for (int p = 0; p < NP; p++) begin
               pt_t_q[c][p] <= '0;
               pt_c_q[c][p] <= '0;
            end
         end
      end else begin
         for (int c = 0; c < NC; c++) begin
            for (int p = 0; p < NP; p++) begin
               if (ctl_en[c] && cell_ok && a_w[4:2] >= clm_pkg::W_PT_GRP
                   && 32'(a_pt) == p) begin
                  case (a_w[1:0])
                     2'h0: pt_t_q[c][p][31:0]    <= pwdata;
                     2'h1: pt_t_q[c][p][PW-1:32] <= pwdata[PW-33:0];
                     2'h2: pt_c_q[c][p][31:0]    <= pwdata;
                     default: pt_c_q[c][p][PW-1:32] <= pwdata[PW-33:0];
                  endcase
               end
            end
         end
      end
   end

   // Switch matrix selectors, four per word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int b = 0; b < NB; b++) begin
            for (int k = 0; k < SMW; k++) begin
               sm_sel_q[b][k] <= '0;
            end
         end
      end else if (wr_go && sm_ok && !fuse_q) begin
         for (int k = 0; k < 4; k++) begin
            sm_sel_q[a_blk][4 * a_smw + k] <= pwdata[8 * k +: 8];
         end
      end
   end

   // Signature and fuse; only reset clears the fuse, as an erase would.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_q  <= clm_pkg::SIG_RST;
         fuse_q <= 1'b0;
      end else if (wr_go) begin
         if (paddr == clm_pkg::SIG_ADDR && !fuse_q) begin
            sig_q <= pwdata[15:0];
         end
         if (paddr == clm_pkg::FUSE_ADDR && pwdata[0]) begin
            fuse_q <= 1'b1;
         end
      end
   end

   // Read mux; protected configuration reads as zero, signature does not.
   always_comb begin
      rd_d   = '0;
      rd_err = 1'b0;
      if (cell_ok) begin
         if (fuse_q) begin
            rd_d = '0;
         end else if (a_w == clm_pkg::W_CTL) begin
            rd_d = ctl_q[a_cell];
         end else if (a_w == clm_pkg::W_PTSEL) begin
            rd_d = ptsel_q[a_cell];
         end else begin
            case (a_w[1:0])
               2'h0: rd_d = pt_t_q[a_cell][a_pt][31:0];
               2'h1: rd_d = 32'(pt_t_q[a_cell][a_pt][PW-1:32]);
               2'h2: rd_d = pt_c_q[a_cell][a_pt][31:0];
               default: rd_d = 32'(pt_c_q[a_cell][a_pt][PW-1:32]);
            endcase
         end
      end else if (sm_ok) begin
         for (int k = 0; k < 4; k++) begin
            rd_d[8 * k +: 8] = fuse_q ? 8'h00 :
                               sm_sel_q[a_blk][4 * a_smw + k];
         end
      end else if (paddr == clm_pkg::SIG_ADDR) begin
         rd_d = {16'h0000, sig_q};
      end else if (paddr == clm_pkg::FUSE_ADDR) begin
         rd_d = {31'h0000_0000, fuse_q};
      end else if (paddr == clm_pkg::STLO_ADDR) begin
         rd_d = cell_q[31:0];
      end else if (paddr == clm_pkg::STHI_ADDR) begin
         rd_d = cell_q[NC-1:32];
      end else begin
         rd_err = 1'b1;
      end
   end

   // APB answer: one wait state, then pready with data for one cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc && rd_err;
         prdata  <= (acc && !pwrite) ? rd_d : '0;
      end
   end

endmodule : clm_macrocell_array

// >>> core/clm_pkg.sv
// Constants, field layouts and the register map of the macrocell array.
// Assumes a single pclk domain and an APB master with 32-bit data.
// Notes on behaviour
// - Every cell has five product terms over global and regional inputs.
// - A selector hands product terms to sum gates and control signals.
// - OR gate sums five terms; cascade chains reach forty terms.
// - XOR second input is a product term, high or low.
// - Storage data comes from XOR output, a product term or the pin.
// - Product-term data gives registered feedback with combinational pin.
// - Storage works as D, T, JK or SR flip-flop.
// - Latch mode passes data while clock high, holds while low.
// - Clock is one of three global lines or a term; rising edge.
// - With a global clock, a low enable term ignores clock edges.
// - Clear is global, a term, their OR, or never.
// - Preset is a product term or never.
// - Pin output is registered or combinational per cell.
// - Buried feedback picks registered or combinational on its own.
// - Output buffer may be always on or always off.
// - Output enable from two enable pins, an I/O pin or a term.
// - Dedicated pins 0 to 2 may be clocks, pin 3 the clear, pins 1 and 2 enables, per cell.
// - Global bus holds all pins and all 64 cell feedbacks.
// - Each block switch matrix picks up to 40 global signals.
// - Each cell drives a foldback term onto its regional bus.
// - Signature stays readable; the fuse protects configuration.
// - Foldback is an inverted product term; sixteen per region.
package clm_pkg;

   // Array sizes.
   localparam int NCELL   = 64;
   localparam int CPB     = 16;
   localparam int NBLK    = 4;
   localparam int NPT     = 5;
   localparam int SM_W    = 40;
   localparam int PT_IN_W = 56;
   localparam int NPIN    = 64;
   localparam int NDED    = 4;
   localparam int GB_W    = NDED + NPIN + NCELL;
   localparam int CAS_MAX = 8;
   localparam int SM_WRDS = 10;

   // Roles of the dedicated input pins.
   localparam int GCLR_PIN = 3;
   localparam int OE_PIN0  = 1;
   localparam int OE_PIN1  = 2;

   // Byte addresses, then word and group indexes inside a cell.
   localparam logic [13:0] SM_BASE   = 14'h2000;
   localparam logic [13:0] SIG_ADDR  = 14'h3000;
   localparam logic [13:0] FUSE_ADDR = 14'h3004;
   localparam logic [13:0] STLO_ADDR = 14'h3008;
   localparam logic [13:0] STHI_ADDR = 14'h300C;
   localparam logic [4:0]  W_CTL     = 5'h00;
   localparam logic [4:0]  W_PTSEL   = 5'h01;
   localparam logic [2:0]  W_PT_GRP  = 3'h2;

   // Control word fields.
   localparam int OR_MASK_LSB = 0;
   localparam int CAS_EN_BIT  = 5;
   localparam int XOR_SEL_LSB = 6;
   localparam int D_SEL_LSB   = 8;
   localparam int MODE_LSB    = 10;
   localparam int CLK_SEL_LSB = 13;
   localparam int CE_EN_BIT   = 15;
   localparam int CLR_SEL_LSB = 16;
   localparam int PRE_EN_BIT  = 18;
   localparam int OUT_REG_BIT = 19;
   localparam int FB_REG_BIT  = 20;
   localparam int OE_SEL_LSB  = 21;
   localparam int OE_PIN_LSB  = 24;

   // Term selector word fields, three bits each.
   localparam int XOR_PT_LSB  = 0;
   localparam int DAT_PT_LSB  = 3;
   localparam int CLK_PT_LSB  = 6;
   localparam int CE_PT_LSB   = 9;
   localparam int CLR_PT_LSB  = 12;
   localparam int PRE_PT_LSB  = 15;
   localparam int OE_PT_LSB   = 18;
   localparam int FOLD_PT_LSB = 21;

   // Field encodings.
   localparam logic [1:0] XOR_LOW  = 2'h0;
   localparam logic [1:0] XOR_HIGH = 2'h1;
   localparam logic [1:0] DSEL_XOR = 2'h0;
   localparam logic [1:0] DSEL_PT  = 2'h1;
   localparam logic [2:0] MODE_D   = 3'h0;
   localparam logic [2:0] MODE_T   = 3'h1;
   localparam logic [2:0] MODE_JK  = 3'h2;
   localparam logic [2:0] MODE_SR  = 3'h3;
   localparam logic [2:0] MODE_LAT = 3'h4;
   localparam logic [1:0] CLK_PT   = 2'h3;
   localparam logic [1:0] CLR_GLB  = 2'h1;
   localparam logic [1:0] CLR_PT   = 2'h2;
   localparam logic [1:0] CLR_OR   = 2'h3;
   localparam logic [2:0] OE_ON    = 3'h1;
   localparam logic [2:0] OE_DED0  = 3'h2;
   localparam logic [2:0] OE_DED1  = 3'h3;
   localparam logic [2:0] OE_IO    = 3'h4;
   localparam logic [2:0] OE_PT    = 3'h5;

   // Values after reset.
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [15:0] SIG_RST = 16'h0000;

endpackage : clm_pkg

// >>> bench/clm_macrocell_array_chk.sv
// Checker for the APB and pin ports of the macrocell array.
// Assumes one pclk domain; bound to every instance of the array.
`timescale 1ns/1ps
module clm_macrocell_array_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [13:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [63:0] io_out,
   input wire logic [63:0] io_oe_n
);
   // All checks share pclk and stay quiet while reset is held.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_answers: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without an access");
   a_err_unmapped: assert property (
      psel && penable && !pready && paddr[13:4] >= 10'h301 |=> pslverr)
      else $error("unmapped address not refused");
   a_err_signature: assert property (
      psel && penable && !pready && paddr[13:4] == 10'h300 |=> !pslverr)
      else $error("status words refused");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero outside answer");
   a_reset_pins: assert property (
      $rose(presetn) |-> (&io_oe_n) && io_out == 64'h0)
      else $error("pins driven right after reset");
endmodule : clm_macrocell_array_chk

bind clm_macrocell_array clm_macrocell_array_chk i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .io_out(io_out), .io_oe_n(io_oe_n));

// >>> bench/clm_board_model.sv
// Board model: drives the pins that the array leaves undriven.
// Assumes a pull-up on every pin, so a released pin never reads stale.
`timescale 1ns/1ps
module clm_board_model (
   input  wire logic [63:0] io_out,
   input  wire logic [63:0] io_oe_n,
   input  wire logic [63:0] drv_en,
   input  wire logic [63:0] drv_val,
   output logic      [63:0] io_in
);
   // Wire level: the array where it drives, else the board, else pull-up.
   assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv_en & drv_val)
                | (io_oe_n & ~drv_en);
endmodule : clm_board_model

// >>> bench/clm_macrocell_array_tb.sv
// Testbench for the macrocell array: APB setup, then pin-level checks.
// Cell 0 drives pin 0; the board drives pin 1, routed to matrix input 0.
`timescale 1ns/1ps
module clm_macrocell_array_tb;
   localparam logic [31:0] OE_W  = 32'h0020_0000;
   localparam logic [31:0] REG_W = 32'h0008_0000;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [13:0] paddr    = '0;
   logic [31:0] pwdata   = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  ded_in   = '0;
   logic [63:0] io_in;
   logic [63:0] io_out;
   logic [63:0] io_oe_n;
   logic [63:0] drv_val  = '0;
   logic [63:0] drv_en   = 64'h0000_0000_0000_0002;
   int          num_errors  = 0;
   int          comparisons = 0;
   int          cycles      = 0;

   clm_macrocell_array i_clm_macrocell_array (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ded_in(ded_in), .io_in(io_in), .io_out(io_out),
      .io_oe_n(io_oe_n));
   clm_board_model i_clm_board_model (.io_out(io_out), .io_oe_n(io_oe_n),
      .drv_en(drv_en), .drv_val(drv_val), .io_in(io_in));

   // The 100 ns clock.
   always #50 pclk = ~pclk;

   // A hung handshake would stall forever, so cycles are capped.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("[FAIL] %0t run too long", $time);
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, exp, input string m);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [13:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x, "read data");
      chk({31'h0, e}, {31'h0, xe}, "slave error");
   endtask : rd

   // Pins pass two sync flops and a register, so eight cycles settle them.
   task automatic pins(input logic [3:0] d, input logic p);
      @(posedge pclk);
      ded_in <= d;
      drv_val[1] <= p;
      repeat (8) @(posedge pclk);
   endtask : pins

   task automatic t_regs;
      rd(clm_pkg::SIG_ADDR, 32'(clm_pkg::SIG_RST), 1'b0);
      rd(14'h0000, clm_pkg::CFG_RST, 1'b0);
      wr(clm_pkg::SIG_ADDR, 32'h0000_5A3C);
      rd(clm_pkg::SIG_ADDR, 32'h0000_5A3C, 1'b0);
      wr(14'h3010, 32'hFFFF_FFFF);
      rd(14'h3010, 32'h0000_0000, 1'b1);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_comb;
      logic x;
      logic v;
      wr(clm_pkg::SM_BASE, 32'h0000_0005);
      wr(14'h0020, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         x = i[1];
         v = i[0];
         wr(14'h0000, 32'h0000_0001 | OE_W | (32'(x) << 6));
         pins(4'h0, v);
         chk({31'h0, io_out[0]}, {31'h0, v ^ x}, "sum output");
         chk({31'h0, io_oe_n[0]}, 32'h0, "pin enable on");
      end
      wr(14'h0000, 32'h0000_0001);
      pins(4'h0, 1'b0);
      chk({31'h0, io_oe_n[0]}, 32'h1, "pin enable off");
      wr(14'h0000, 32'h0040_0001);
      pins(4'h2, 1'b0);
      chk({31'h0, io_oe_n[0]}, 32'h0, "enable pin high");
      pins(4'h0, 1'b0);
      chk({31'h0, io_oe_n[0]}, 32'h1, "enable pin low");
      $display("t_comb done");
   endtask : t_comb

   task automatic t_seq;
      logic [31:0] c;
      c = 32'h0000_0001 | REG_W | OE_W;
      wr(14'h0000, c);
      wr(14'h0004, 32'h0000_0200);
      pins(4'h0, 1'b1);
      chk({31'h0, io_out[0]}, 32'h0, "no edge");
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h1, "rising edge");
      pins(4'h0, 1'b0);
      chk({31'h0, io_out[0]}, 32'h1, "falling edge");
      pins(4'h1, 1'b0);
      chk({31'h0, io_out[0]}, 32'h0, "edge loads low");
      wr(14'h0000, c | 32'h0000_8000);
      pins(4'h0, 1'b1);
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h0, "enable low");
      wr(14'h0000, c | 32'h0000_0400);
      pins(4'h0, 1'b1);
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h1, "toggle up");
      pins(4'h0, 1'b1);
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h0, "toggle down");
      wr(14'h0000, c | 32'h0000_1000);
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h1, "latch open");
      pins(4'h1, 1'b0);
      chk({31'h0, io_out[0]}, 32'h0, "latch follows");
      pins(4'h0, 1'b0);
      pins(4'h0, 1'b1);
      chk({31'h0, io_out[0]}, 32'h0, "latch holds");
      wr(14'h0000, c | 32'h0000_0800);
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h1, "jk toggles up");
      pins(4'h0, 1'b1);
      pins(4'h1, 1'b1);
      chk({31'h0, io_out[0]}, 32'h0, "jk toggles down");
      wr(14'h0000, c | 32'h0005_0000);
      pins(4'h0, 1'b1);
      chk({31'h0, io_out[0]}, 32'h1, "preset term");
      pins(4'h8, 1'b1);
      chk({31'h0, io_out[0]}, 32'h0, "clear wins");
      $display("t_seq done");
   endtask : t_seq

   task automatic t_fuse;
      wr(clm_pkg::FUSE_ADDR, 32'h0000_0001);
      rd(clm_pkg::FUSE_ADDR, 32'h0000_0001, 1'b0);
      wr(clm_pkg::SIG_ADDR, 32'h0000_1111);
      rd(clm_pkg::SIG_ADDR, 32'h0000_5A3C, 1'b0);
      rd(14'h0000, 32'h0000_0000, 1'b0);
      wr(14'h0000, 32'h0000_0000);
      pins(4'h0, 1'b0);
      chk({31'h0, io_oe_n[0]}, 32'h0, "fused config kept");
      $display("t_fuse done");
   endtask : t_fuse

   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // Reset for twelve cycles, then run every scenario in turn.
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_comb();
      t_seq();
      t_fuse();
      tally_and_finish();
   end
endmodule : clm_macrocell_array_tb
